// [cam_ctrl.sv]
// Mode control, shared counter, capture, match and waveform logic of a six-module counter array.
//
// Operation
// R1 - PWM enabled: wide select 1 gives 16-bit PWM, 0 gives 8-to-11-bit PWM.
// R2 - Comparator enable bit turns on counter versus capture/compare register comparison.
// R3 - Rising capture enable makes the module capture on positive input edges.
// R4 - Falling capture enable makes the module capture on negative input edges.
// R5 - With match enabled, counter equal to compare value sets the event flag.
// R6 - With toggle enabled, each match inverts the module output pin.
// R7 - Toggle and PWM both set selects frequency output mode.
// R8 - PWM enable drives a pulse-width-modulated waveform on the output pin.
// R9 - Event flag requests an interrupt only when its interrupt enable bit is set.
// R10 - Watchdog lock blocks module 5 mode writes; module 5 serves as watchdog.
// R11 - Counter seen as low byte and high byte registers, both reset to zero.
// R12 - Watchdog lock blocks software writes to both counter byte registers.
// R13 - High byte reads a snapshot loaded only when the low byte is read.
// R14 - Shared length select gives 8, 9, 10 bits for codes 00, 01, 10.
// R15 - Compare low byte write clears comparator enable; high byte write sets it.
// R16 - Enabled capture edge copies counter into compare register and sets event flag.
// R17 - All mode bits reset to zero: modules inactive, interrupts masked.
`timescale 1ns/100ps
module cam_ctrl
   import cam_pkg::*;
#(
   parameter int NUM_MODULES = CAM_MODULES
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // Special function register port
   input wire cam_sfr_req_t sfr_req_i,
   output logic [7:0] sfr_rdata_o,
   // Array-level controls
   input wire logic count_tick_i,
   input wire logic watchdog_lock_enable_i,
   input wire logic [1:0] cycle_length_select_i,
   input wire logic [NUM_MODULES-1:0] flag_clear_i,
   // Module pins
   input wire logic [NUM_MODULES-1:0] module_pin_i,
   output logic [NUM_MODULES-1:0] module_output_pin_o,
   output logic [NUM_MODULES-1:0] module_output_pin_oe_o,
   // Status
   output logic [NUM_MODULES-1:0] module_event_flag_o,
   output logic [CAM_CNT_W-1:0] shared_counter_o,
   output logic watchdog_match_o,
   output logic irq_o
);

   // ***************************************************************
   // Elaboration check
   // ***************************************************************
   // The register map is fixed for six modules, so other counts cannot be decoded.
   if (NUM_MODULES != CAM_MODULES) begin : g_bad_count
      $error("cam_ctrl supports exactly six modules");
   end
   // Byte registers split the counter at bit 8, so only a 16-bit counter fits.
   if (CAM_CNT_W != 16) begin : g_bad_width
      $error("cam_ctrl needs a 16-bit counter");
   end
   // One module doubles as the watchdog, so it must exist.
   if (CAM_WDOG_MODULE >= NUM_MODULES) begin : g_bad_wdog
      $error("cam_ctrl watchdog module out of range");
   end

   // ***************************************************************
   // State
   // ***************************************************************
   typedef struct packed {
      cam_mode_t [NUM_MODULES-1:0] mode;
      logic [NUM_MODULES-1:0][CAM_CNT_W-1:0] ccr;
      logic [NUM_MODULES-1:0] flag;
      logic [NUM_MODULES-1:0] pin_out;
      logic [NUM_MODULES-1:0] sync1;
      logic [NUM_MODULES-1:0] sync2;
      logic [NUM_MODULES-1:0] prev;
      logic [CAM_CNT_W-1:0] cnt;
      logic [7:0] snap;
      logic [7:0] rdata;
      logic ticked;
      logic wdog_hit;
   } cam_state_t;

   cam_state_t s_q;
   cam_state_t s_d;

   // ***************************************************************
   // Address decode
   // ***************************************************************
   logic [NUM_MODULES-1:0] sel_mode;
   logic [NUM_MODULES-1:0] sel_cmp_low;
   logic [NUM_MODULES-1:0] sel_cmp_high;
   logic [NUM_MODULES-1:0] mode_locked;
   logic sel_cnt_low;
   logic sel_cnt_high;
   logic cnt_wr_ok;
   logic [7:0] rd_value;

   // Software may move the counter only while the watchdog lock is off.
   assign sel_cnt_low = (sfr_req_i.addr == CAM_CNT_LOW_ADDR);
   assign sel_cnt_high = (sfr_req_i.addr == CAM_CNT_HIGH_ADDR);
   assign cnt_wr_ok = sfr_req_i.wr && !watchdog_lock_enable_i; // R12

   always_comb begin
      for (int n = 0; n < NUM_MODULES; n++) begin
         sel_mode[n] = (sfr_req_i.addr == CAM_MODE_ADDR[n]);
         sel_cmp_low[n] = (sfr_req_i.addr == CAM_CMP_LOW_ADDR[n]);
         sel_cmp_high[n] = (sfr_req_i.addr == CAM_CMP_HIGH_ADDR[n]);
         mode_locked[n] = watchdog_lock_enable_i && (n == CAM_WDOG_MODULE); // R10
      end
   end

   // ***************************************************************
   // Read multiplexer
   // ***************************************************************
   // Unmapped addresses read as zero; the snapshot itself is loaded in the next-state logic.
   always_comb begin
      rd_value = CAM_BYTE_ZERO;
      if (sel_cnt_low) begin
         rd_value = s_q.cnt[7:0]; // R11
      end
      if (sel_cnt_high) begin
         rd_value = s_q.snap; // R13
      end
      for (int n = 0; n < NUM_MODULES; n++) begin
         if (sel_mode[n]) begin
            rd_value = s_q.mode[n];
         end
         if (sel_cmp_low[n]) begin
            rd_value = s_q.ccr[n][7:0];
         end
         if (sel_cmp_high[n]) begin
            rd_value = s_q.ccr[n][15:8];
         end
      end
   end

   // ***************************************************************
   // Helpers
   // ***************************************************************
   function automatic logic [CAM_CNT_W-1:0] len_mask(input logic [1:0] sel);
      logic [CAM_CNT_W-1:0] m;
      m = 16'h00ff;
      unique case (sel)
         CAM_LEN_8: m = 16'h00ff;
         CAM_LEN_9: m = 16'h01ff;
         CAM_LEN_10: m = 16'h03ff;
         CAM_LEN_11: m = 16'h07ff;
      endcase
      return m;
   endfunction

   function automatic cam_fn_t module_fn(input cam_mode_t m);
      cam_fn_t f;
      f = CAM_FN_OFF;
      if (m.toggle_enable && m.pwm_output_enable) begin
         f = CAM_FN_FREQ; // R7
      end else if (m.pwm_output_enable) begin
         f = CAM_FN_PWM; // R8
      end else if (m.toggle_enable) begin
         f = CAM_FN_TOGGLE;
      end
      return f;
   endfunction

   // Frequency output matches on the low byte only; narrow PWM on the field that the cycle length selects.
   function automatic logic compare_hit(input cam_mode_t m, input logic [CAM_CNT_W-1:0] cnt,
      input logic [CAM_CNT_W-1:0] ccr, input logic [CAM_CNT_W-1:0] mask);
      logic h;
      h = 1'b0;
      unique case (module_fn(m))
         CAM_FN_FREQ: h = (cnt[7:0] == ccr[7:0]);
         CAM_FN_PWM: h = m.wide_pwm_select ? (cnt == ccr) : ((cnt & mask) == (ccr & mask));
         CAM_FN_TOGGLE, CAM_FN_OFF: h = (cnt == ccr);
      endcase
      return h;
   endfunction

   // The waveform is high while the counter field has reached the compare value.
   // With the comparator off the pin rests low, so a module can be parked quietly.
   function automatic logic pwm_level(input cam_mode_t m, input logic [CAM_CNT_W-1:0] cnt,
      input logic [CAM_CNT_W-1:0] ccr, input logic [CAM_CNT_W-1:0] mask);
      logic l;
      l = 1'b0;
      if (m.comparator_enable) begin
         if (m.wide_pwm_select) begin
            l = (cnt >= ccr); // R1 R8
         end else begin
            l = ((cnt & mask) >= (ccr & mask)); // R1 R14
         end
      end
      return l;
   endfunction

   // ***************************************************************
   // Next-state logic
   // ***************************************************************
   always_comb begin
      cam_mode_t m;
      logic [CAM_CNT_W-1:0] mask;
      logic rise;
      logic fall;
      logic hit;
      m = '0;
      mask = len_mask(cycle_length_select_i); // R14
      rise = 1'b0;
      fall = 1'b0;
      hit = 1'b0;
      s_d = s_q;
      s_d.wdog_hit = 1'b0;
      s_d.ticked = count_tick_i;

      // Pins cross into the clock domain through two flip-flops.
      s_d.sync1 = module_pin_i;
      s_d.sync2 = s_q.sync1;
      s_d.prev = s_q.sync2;

      // Counter advances on each tick; software writes below take priority.
      if (count_tick_i) begin
         s_d.cnt = s_q.cnt + 16'h0001;
      end

      // Register writes.
      if (cnt_wr_ok && sel_cnt_low) begin
         s_d.cnt[7:0] = sfr_req_i.wdata; // R11 R12
      end
      if (cnt_wr_ok && sel_cnt_high) begin
         s_d.cnt[15:8] = sfr_req_i.wdata; // R11 R12
      end
      if (sfr_req_i.wr) begin
         for (int n = 0; n < NUM_MODULES; n++) begin
            if (sel_mode[n] && !mode_locked[n]) begin
               s_d.mode[n] = cam_mode_t'(sfr_req_i.wdata); // R10
            end
            if (sel_cmp_low[n]) begin
               s_d.ccr[n][7:0] = sfr_req_i.wdata;
               if (!mode_locked[n]) begin
                  s_d.mode[n].comparator_enable = 1'b0; // R15
               end
            end
            if (sel_cmp_high[n]) begin
               s_d.ccr[n][15:8] = sfr_req_i.wdata;
               if (!mode_locked[n]) begin
                  s_d.mode[n].comparator_enable = 1'b1; // R15
               end
            end
         end
      end

      // Register reads answer one cycle later from a flip-flop.
      if (sfr_req_i.rd) begin
         s_d.rdata = rd_value;
         if (sel_cnt_low) begin
            s_d.snap = s_q.cnt[15:8]; // R13
         end
      end

      // Per-module capture, match and waveform.
      for (int n = 0; n < NUM_MODULES; n++) begin
         m = cam_mode_t'(s_q.mode[n]);
         rise = s_q.sync2[n] && !s_q.prev[n];
         fall = !s_q.sync2[n] && s_q.prev[n];

         // Software clear first so that a same-cycle event still sets the flag.
         if (flag_clear_i[n]) begin
            s_d.flag[n] = 1'b0;
         end

         if ((m.rising_capture_enable && rise) || (m.falling_capture_enable && fall)) begin // R3 R4
            s_d.ccr[n] = s_q.cnt; // R16
            s_d.flag[n] = 1'b1; // R16
         end

         // Comparison is judged once, the cycle after the counter moved,
         // so a counter that stands still does not raise repeated events.
         if (m.comparator_enable && s_q.ticked) begin // R2
            hit = compare_hit(m, s_q.cnt, s_q.ccr[n], mask);
         end else begin
            hit = 1'b0;
         end

         if (hit && m.match_flag_enable) begin
            s_d.flag[n] = 1'b1; // R5
         end
         if (hit && n == CAM_WDOG_MODULE && watchdog_lock_enable_i) begin
            s_d.wdog_hit = 1'b1; // R10
         end

         unique case (module_fn(m))
            CAM_FN_TOGGLE: begin
               if (hit) begin
                  s_d.pin_out[n] = !s_q.pin_out[n]; // R6
               end
            end
            CAM_FN_FREQ: begin
               if (hit) begin
                  s_d.pin_out[n] = !s_q.pin_out[n]; // R7
               end
            end
            CAM_FN_PWM: begin
               s_d.pin_out[n] = pwm_level(m, s_q.cnt, s_q.ccr[n], mask); // R1 R8
            end
            CAM_FN_OFF: begin
               s_d.pin_out[n] = s_q.pin_out[n];
            end
         endcase
      end
   end

   // ***************************************************************
   // State register
   // ***************************************************************
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_q <= '0; // R11 R17
      end else begin
         s_q <= s_d;
      end
   end

   // ***************************************************************
   // Outputs
   // ***************************************************************
   always_comb begin
      for (int n = 0; n < NUM_MODULES; n++) begin
         module_output_pin_oe_o[n] = (module_fn(cam_mode_t'(s_q.mode[n])) != CAM_FN_OFF);
      end
   end

   assign module_output_pin_o = s_q.pin_out;
   assign module_event_flag_o = s_q.flag;
   assign shared_counter_o = s_q.cnt;
   assign sfr_rdata_o = s_q.rdata;
   assign watchdog_match_o = s_q.wdog_hit;

   // ***************************************************************
   // Interrupt request
   // ***************************************************************
   // The interrupt request is a registered-flag AND mask, so it follows the flag with no added delay.
   always_comb begin
      irq_o = 1'b0;
      for (int n = 0; n < NUM_MODULES; n++) begin
         if (s_q.flag[n] && s_q.mode[n].module_flag_irq_enable) begin
            irq_o = 1'b1; // R9
         end
      end
   end

endmodule

// [cam_ctrl_chk.sv]
// Assertion checker for the counter array module control block.
`timescale 1ns/100ps
module cam_ctrl_chk
   import cam_pkg::*;
#(
   parameter int NUM_MODULES = CAM_MODULES
) (
   // Clock, reset and register port
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire cam_sfr_req_t sfr_req_i,
   input wire logic [7:0] sfr_rdata_o,
   // Controls and status
   input wire logic count_tick_i,
   input wire logic watchdog_lock_enable_i,
   input wire logic [NUM_MODULES-1:0] flag_clear_i,
   input wire logic [NUM_MODULES-1:0] module_output_pin_oe_o,
   input wire logic [NUM_MODULES-1:0] module_event_flag_o,
   input wire logic [CAM_CNT_W-1:0] shared_counter_o,
   input wire logic watchdog_match_o,
   input wire logic irq_o
);
   logic cwr, seen_q;
   assign cwr = sfr_req_i.wr && !watchdog_lock_enable_i &&
      sfr_req_i.addr inside {CAM_CNT_LOW_ADDR, CAM_CNT_HIGH_ADDR};
   // Output enables and the interrupt request may leave their reset state only after software has written a mode register.
   always_ff @(posedge core_clk_i or posedge rst_i)
      if (rst_i)
         seen_q <= 1'b0;
      else if (sfr_req_i.wr && sfr_req_i.addr inside {[8'hda:8'hdf]})
         seen_q <= 1'b1;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   sequence s_rd(logic [7:0] a);
      sfr_req_i.rd && sfr_req_i.addr == a;
   endsequence
   property p_cnt;
      !cwr |=> shared_counter_o == $past(shared_counter_o) + 16'($past(count_tick_i));
   endproperty
   property p_wlow;
      cwr && sfr_req_i.addr == CAM_CNT_LOW_ADDR |=> shared_counter_o[7:0] == $past(sfr_req_i.wdata);
   endproperty
   property p_low;
      s_rd(CAM_CNT_LOW_ADDR) |=> sfr_rdata_o == $past(shared_counter_o[7:0]);
   endproperty
   property p_snap;
      s_rd(CAM_CNT_LOW_ADDR) ##1 s_rd(CAM_CNT_HIGH_ADDR) |=> sfr_rdata_o == $past(shared_counter_o[15:8], 2);
   endproperty
   property p_irq;
      irq_o |-> module_event_flag_o != '0;
   endproperty
   property p_rst;
      !seen_q |-> module_output_pin_oe_o == '0 && !irq_o;
   endproperty
   property p_wdog;
      watchdog_match_o |-> $past(watchdog_lock_enable_i);
   endproperty
   property p_flag;
      1'b1 |-> ($past(module_event_flag_o) & ~module_event_flag_o & ~$past(flag_clear_i)) == '0;
   endproperty
   a_cnt: assert property (p_cnt) else $error("counter step wrong");
   a_wlow: assert property (p_wlow) else $error("low byte write lost");
   a_low: assert property (p_low) else $error("low byte read wrong");
   a_snap: assert property (p_snap) else $error("snapshot read wrong");
   a_irq: assert property (p_irq) else $error("interrupt without flag");
   a_rst: assert property (p_rst) else $error("output active before mode write");
   a_wdog: assert property (p_wdog) else $error("watchdog hit without lock");
   a_flag: assert property (p_flag) else $error("flag fell without clear");
endmodule
bind cam_ctrl cam_ctrl_chk #(.NUM_MODULES(NUM_MODULES)) cam_ctrl_chk_inst (.*);

// [cam_pins.sv]
// Behavioural model of the signals that drive the module capture pins.
`timescale 1ns/100ps
module cam_pins (
   // Wanted levels and pins
   input wire logic [5:0] lvl_i,
   output logic [5:0] pin_o
);
   // The pins are asynchronous, so each change lands well away from a clock edge.
   initial pin_o = '0;
   always @(lvl_i) pin_o <= #37 lvl_i;
endmodule

// [cam_pkg.sv]
// Constants, register map and carrier types of the counter array module control block.
package cam_pkg;

   // ***************************************************************
   // Geometry
   // ***************************************************************
   localparam int CAM_MODULES = 6;
   localparam int CAM_CNT_W = 16;
   localparam int CAM_WDOG_MODULE = 5;

   // ***************************************************************
   // Register addresses, index n of each packed array is module n
   // ***************************************************************
   localparam logic [5:0][7:0] CAM_MODE_ADDR = {8'hdf, 8'hde, 8'hdd, 8'hdc, 8'hdb, 8'hda};
   localparam logic [5:0][7:0] CAM_CMP_LOW_ADDR = {8'hce, 8'hfd, 8'hed, 8'heb, 8'he9, 8'hfb};
   localparam logic [5:0][7:0] CAM_CMP_HIGH_ADDR = {8'hcf, 8'hfe, 8'hee, 8'hec, 8'hea, 8'hfc};
   localparam logic [7:0] CAM_CNT_LOW_ADDR = 8'hf9;
   localparam logic [7:0] CAM_CNT_HIGH_ADDR = 8'hfa;

   // ***************************************************************
   // Reset values and encodings
   // ***************************************************************
   localparam logic [7:0] CAM_MODE_RESET = 8'h00;
   localparam logic [15:0] CAM_CNT_RESET = 16'h0000;
   localparam logic [7:0] CAM_BYTE_ZERO = 8'h00;
   localparam logic [1:0] CAM_LEN_8 = 2'h0;
   localparam logic [1:0] CAM_LEN_9 = 2'h1;
   localparam logic [1:0] CAM_LEN_10 = 2'h2;
   localparam logic [1:0] CAM_LEN_11 = 2'h3;

   // ***************************************************************
   // Types
   // ***************************************************************
   // Mode register, most significant field first (bit 7 down to bit 0).
   typedef struct packed {
      logic wide_pwm_select;
      logic comparator_enable;
      logic rising_capture_enable;
      logic falling_capture_enable;
      logic match_flag_enable;
      logic toggle_enable;
      logic pwm_output_enable;
      logic module_flag_irq_enable;
   } cam_mode_t;

   // One access on the special function register port.
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cam_sfr_req_t;

   typedef enum logic [1:0] {
      CAM_FN_OFF = 2'h0,
      CAM_FN_TOGGLE = 2'h1,
      CAM_FN_PWM = 2'h2,
      CAM_FN_FREQ = 2'h3
   } cam_fn_t;

endpackage

// [counter_array_module_control_bench.sv]
// Self-checking bench of the counter array module control block.
`timescale 1ns/100ps
module counter_array_module_control_bench;
   import cam_pkg::*;
   cam_sfr_req_t req = '0;
   logic clk = 0, rst = 1, tick = 0, lock = 0, wdm, irq, ws = 0, e, p;
   logic [1:0] len = 0;
   logic [5:0] clr = 0, lvl = 0, pin, po, oe, fl;
   logic [7:0] rdata, r, x = 8'h40;
   logic [15:0] co, mk;
   int errors = 0, compares = 0, cnt = 0, cyc = 0;
   cam_ctrl cam_ctrl_inst (.core_clk_i(clk), .rst_i(rst), .sfr_req_i(req), .sfr_rdata_o(rdata),
      .count_tick_i(tick), .watchdog_lock_enable_i(lock), .cycle_length_select_i(len),
      .flag_clear_i(clr), .module_pin_i(pin), .module_output_pin_o(po), .module_output_pin_oe_o(oe),
      .module_event_flag_o(fl), .shared_counter_o(co), .watchdog_match_o(wdm), .irq_o(irq));
   cam_pins cam_pins_inst (.lvl_i(lvl), .pin_o(pin));
   initial forever #50 clk = ~clk;
   // The watchdog pulse lasts one cycle, so it is latched for a later look.
   always @(posedge clk) begin
      ws <= ws | wdm;
      cyc++;
      if (cyc == 5000) begin
         errors++;
         results();
      end
   end
   function automatic logic [7:0] lf(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   task automatic results();
      $display("checks %0d mismatches %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string n, input logic [15:0] s, input logic [15:0] ex);
      compares++;
      if (s !== ex) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", n, ex, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk) req = '{1'b1, 1'b0, a, d};
      @(negedge clk) req = '0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(negedge clk) req = '{1'b0, 1'b1, a, 8'h00};
      @(negedge clk) req = '0;
      r = rdata;
   endtask
   task automatic tk();
      @(negedge clk) tick = 1;
      @(negedge clk) tick = 0;
      cnt++;
      repeat (2) @(negedge clk);
   endtask
   task automatic setc(input logic [15:0] v);
      wr(CAM_CNT_LOW_ADDR, v[7:0]);
      wr(CAM_CNT_HIGH_ADDR, v[15:8]);
      cnt = v;
   endtask
   initial begin
      repeat (3) @(negedge clk);
      rst = 0;
      chk("counter", co, 16'h0000);
      for (int m = 0; m < 6; m++) begin
         rd(CAM_MODE_ADDR[m]);
         chk("mode", 16'(r), 16'(CAM_MODE_RESET));
         x = lf(x);
         wr(CAM_MODE_ADDR[m], x);
         rd(CAM_MODE_ADDR[m]);
         chk("mode", 16'(r), 16'(x));
         wr(CAM_MODE_ADDR[m], 8'h00);
      end
      $display("test registers done");
      setc(16'h12ff);
      rd(CAM_CNT_LOW_ADDR);
      chk("low", 16'(r), 16'h00ff);
      tk();
      rd(CAM_CNT_HIGH_ADDR);
      chk("snapshot", 16'(r), 16'h0012);
      @(negedge clk) req = '{1'b0, 1'b1, CAM_CNT_LOW_ADDR, 8'h00};
      @(negedge clk) req.addr = CAM_CNT_HIGH_ADDR;
      @(negedge clk) req = '0;
      chk("snapshot", 16'(rdata), 16'(cnt[15:8]));
      lock = 1;
      wr(CAM_CNT_LOW_ADDR, 8'h55);
      wr(CAM_CNT_HIGH_ADDR, 8'h55);
      wr(CAM_MODE_ADDR[5], 8'h21);
      rd(CAM_MODE_ADDR[5]);
      chk("mode5", 16'(r), 16'h0000);
      chk("counter", co, 16'(cnt));
      lock = 0;
      $display("test counter done");
      for (int i = 0; i < 4; i++) begin
         x = lf(x);
         setc({x, 8'h3c});
         wr(CAM_MODE_ADDR[0], i > 1 ? 8'h10 : 8'h21);
         lvl[0] = ~lvl[0];
         repeat (8) @(negedge clk);
         e = i == 0 || i == 3;
         chk("flag", 16'(fl[0]), 16'(e));
         chk("irq", 16'(irq), 16'(e && i < 2));
         if (e) begin
            rd(CAM_CMP_LOW_ADDR[0]);
            chk("capture", 16'(r), 16'h003c);
            rd(CAM_CMP_HIGH_ADDR[0]);
            chk("capture", 16'(r), 16'(x));
         end
         @(negedge clk) clr = 6'h3f;
         @(negedge clk) clr = 6'h00;
         chk("clear", 16'(fl), 16'h0000);
      end
      $display("test capture done");
      wr(CAM_MODE_ADDR[1], 8'h4c);
      wr(CAM_CMP_LOW_ADDR[1], 8'h10);
      rd(CAM_MODE_ADDR[1]);
      chk("ecom", 16'(r), 16'h000c);
      wr(CAM_CMP_HIGH_ADDR[1], 8'h03);
      rd(CAM_MODE_ADDR[1]);
      chk("ecom", 16'(r), 16'h004c);
      setc(16'h030e);
      p = po[1];
      tk();
      chk("toggle", 16'(po[1]), 16'(p));
      chk("match", 16'(fl[1]), 16'h0000);
      tk();
      chk("toggle", 16'(po[1]), 16'(!p));
      chk("match", 16'(fl[1]), 16'h0001);
      for (int k = 1; k < 5; k++) begin
         wr(CAM_MODE_ADDR[3], 8'(2 * k));
         chk("enable", 16'(oe[3]), 16'(k < 4));
      end
      wr(CAM_MODE_ADDR[4], 8'h06);
      wr(CAM_CMP_LOW_ADDR[4], 8'h11);
      wr(CAM_CMP_HIGH_ADDR[4], 8'h7f);
      setc(16'h0010);
      p = po[4];
      tk();
      chk("freq", 16'(po[4]), 16'(!p));
      $display("test match done");
      wr(CAM_CMP_LOW_ADDR[2], 8'h80);
      wr(CAM_CMP_HIGH_ADDR[2], 8'h01);
      for (int k = 0; k < 16; k++) begin
         mk = k > 13 ? 16'hffff : 16'((1 << (8 + k / 4)) - 1);
         len = 2'(k / 4);
         wr(CAM_MODE_ADDR[2], k > 13 ? 8'hc2 : 8'h42);
         x = lf(x);
         setc({x, lf(x)});
         repeat (2) @(negedge clk);
         chk("pwm", 16'(po[2]), 16'((cnt & mk) >= (16'h0180 & mk)));
      end
      $display("test pwm done");
      wr(CAM_MODE_ADDR[5], 8'h48);
      wr(CAM_CMP_LOW_ADDR[5], 8'h20);
      wr(CAM_CMP_HIGH_ADDR[5], 8'h00);
      setc(16'h001f);
      lock = 1;
      tk();
      chk("watchdog", 16'(ws), 16'h0001);
      chk("counter", co, 16'(cnt));
      $display("test watchdog done");
      results();
   end
endmodule
